// [sfr_result_regs.sv]
// buffer control and proximity and temperature result registers
`timescale 1ns/10ps
// Function
// R1: threshold select zero disables, else seven steps of sixteen; code makes the steps 32 in double data mode
// R2: clear empties buffer, pointers to zero
// R3: clear keeps overflow; data read removes it
// R4: host clears only with ambient unit off
// R5: empty flag set at reset and when empty
// R6: overflow marks full; new results discarded
// R7: low byte: extended low or 10-bit top
// R8: high byte: extended high or 10-bit bottom
// R9: fewer pulses as reflected signal grows
// R10: low byte read latches high byte
// R11: pulse control on extends 10-bit result
// R12: narrow mode: adc times 16 per pulses
// R13: wide mode: adc times 64 per pulses
// R14: pulse control off compares top eight bits
// R15: temperature split low 7:0, high 9:8
// R16: temperature measured after each proximity run; code starts one only with temp_armed, from SFR_IDLE
// R17: level at threshold sets flag and interrupt
// R18: latched high byte held until next low read
module sfr_result_regs #(
   parameter int FIFO_WIDTH = 16,
   parameter int FIFO_DEPTH = 512,
   parameter logic [6:0] MAX_PULSES = 7'h40
) (
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire sfr_pkg::sfr_reg_req_t reg_req,
   output logic [7:0]                 reg_rdata,
   output logic                       reg_rvalid,
   input  wire sfr_pkg::sfr_cfg_t     cfg,
   input  wire logic                  ambient_light_unit_on,
   input  wire logic                  meas_valid,
   input  wire logic [FIFO_WIDTH-1:0] meas_data,
   output logic                       meas_ready,
   input  wire logic                  buf_rd,
   output logic [FIFO_WIDTH-1:0]      buf_rd_data,
   input  wire logic                  buffer_thresh_irq_en,
   input  wire logic                  thresh_flag_clr,
   output logic                       buffer_thresh_flag,
   output logic                       buffer_irq,
   input  wire logic                  prox_done,
   input  wire logic [9:0]            prox_adc,
   output logic [6:0]                 prox_pulse_count,
   input  wire logic [15:0]           prox_low_thresh,
   input  wire logic [15:0]           prox_high_thresh,
   output logic                       prox_below_low,
   output logic                       prox_above_high,
   output logic                       temp_start,
   input  wire logic                  temp_done,
   input  wire logic [9:0]            temp_adc
);
   import sfr_pkg::*;

   localparam int AW = $clog2(FIFO_DEPTH);
   // compare width wide enough for both level and threshold
   localparam int CW = (AW + 1 > 10) ? AW + 1 : 10;

   function automatic logic [9:0] thresh_of(input logic [2:0] sel,
                                            input logic       dbl);
      logic [9:0] t;
      t = 10'(sel) * 10'(THR_STEP);
      return dbl ? 10'(t << 1) : t;
   endfunction : thresh_of

   function automatic logic [15:0] prox_scale(input logic [9:0] adc,
                                              input logic [6:0] pulses,
                                              input logic       wide);
      logic [15:0] num;
      logic [15:0] den;
      num = 16'(adc) * (wide ? SCALE_WIDE : SCALE_NARROW);
      den = (pulses == 7'h00) ? 16'(MIN_PULSES) : 16'(pulses);
      return num / den;
   endfunction : prox_scale

   // reset asserts at once but leaves through two flops
   logic rst_s1_reg, rst_n;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end

   logic             buf_clear;
   logic             buf_empty, buf_full;
   logic [AW:0]      buf_level;
   logic             wr_ready;

   // the clear is a one-cycle action; the host keeps the ambient unit
   // off around it, so a measurement write never races it
   sfr_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH),
      .AW    (AW)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .clear    (buf_clear),                 // R2 R4
      .wr_valid (meas_valid),
      .wr_data  (meas_data),
      .wr_ready (wr_ready),
      .rd_en    (buf_rd),
      .rd_data  (buf_rd_data),               // R5
      .empty    (buf_empty),
      .full     (buf_full),
      .level    (buf_level)
   );

   assign meas_ready = wr_ready; // R6

   // control register and flags
   logic       rsvd_reg, rsvd_next;
   logic [2:0] thr_sel_reg, thr_sel_next;
   logic       ovf_reg, ovf_next;
   logic       tflag_reg, tflag_next;
   logic       ctrl_wr;
   logic [9:0] thr_level;

   assign ctrl_wr   = reg_req.wr && (reg_req.addr == ADDR_BUF_CTRL);
   assign buf_clear = ctrl_wr && reg_req.wdata[BIT_CLEAR];  // R2
   assign thr_level = thresh_of(thr_sel_reg, cfg.double_data_mode); // R1

   always_comb begin
      rsvd_next    = rsvd_reg;
      thr_sel_next = thr_sel_reg;
      if (ctrl_wr) begin
         rsvd_next    = reg_req.wdata[BIT_RSVD];
         thr_sel_next = reg_req.wdata[THR_MSB:THR_LSB];
      end
      // a buffer data read removes overflow; a fresh discard wins
      ovf_next = ovf_reg;
      if (buf_rd) begin
         ovf_next = 1'b0;                                     // R3
      end
      if (meas_valid && buf_full) begin
         ovf_next = 1'b1;                                     // R6
      end
      tflag_next = tflag_reg;
      if (thresh_flag_clr) begin
         tflag_next = 1'b0;
      end
      if (thr_sel_reg != 3'h0 &&
          CW'(buf_level) >= CW'(thr_level)) begin
         tflag_next = 1'b1;                                   // R17 R1
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsvd_reg    <= 1'b0;
         thr_sel_reg <= RST_THR_SEL;
         ovf_reg     <= 1'b0;
         tflag_reg   <= 1'b0;
      end else begin
         rsvd_reg    <= rsvd_next;
         thr_sel_reg <= thr_sel_next;
         ovf_reg     <= ovf_next;
         tflag_reg   <= tflag_next;
      end
   end

   assign buffer_thresh_flag = tflag_reg;
   assign buffer_irq = tflag_reg && buffer_thresh_irq_en;     // R17

   // proximity result and pulse control
   logic [15:0] prox_reg, prox_next;
   logic        prox_raw_reg, prox_raw_next;
   logic [6:0]  pulses_reg, pulses_next;
   logic [7:0]  high_latch_reg, high_latch_next;
   logic        low_rd;
   logic [7:0]  prox_low_byte, prox_high_byte;

   assign low_rd = reg_req.rd && (reg_req.addr == ADDR_PROX_LOW);

   always_comb begin
      prox_next     = prox_reg;
      prox_raw_next = prox_raw_reg;
      pulses_next   = pulses_reg;
      if (prox_done) begin
         prox_raw_next = cfg.pulse_ctrl_off;
         if (cfg.pulse_ctrl_off) begin
            prox_next = 16'(prox_adc);
         end else begin
            // R11 R12 R13
            prox_next = prox_scale(prox_adc, pulses_reg,
                                   cfg.wide_output_on);
            // halving or doubling keeps the adc within its mid range
            if (prox_adc >= PULSE_HIGH_MARK && pulses_reg > MIN_PULSES) begin
               pulses_next = 7'(pulses_reg >> 1);             // R9
            end else if (prox_adc < PULSE_LOW_MARK &&
                         pulses_reg < MAX_PULSES) begin
               pulses_next = 7'(pulses_reg << 1);             // R9
            end
         end
      end
      if (cfg.pulse_ctrl_off) begin
         pulses_next = MAX_PULSES;
      end
   end

   always_comb begin
      if (prox_raw_reg) begin
         prox_low_byte  = prox_reg[9:2];                      // R7
         prox_high_byte = {6'h00, prox_reg[1:0]};             // R8
      end else begin
         prox_low_byte  = prox_reg[7:0];                      // R7
         prox_high_byte = prox_reg[15:8];                     // R8
      end
      high_latch_next = high_latch_reg;
      if (low_rd) begin
         high_latch_next = prox_high_byte;                    // R10 R18
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prox_reg       <= RST_PROX;
         prox_raw_reg   <= 1'b0;
         pulses_reg     <= RST_PULSES;
         high_latch_reg <= RST_BYTE;
      end else begin
         prox_reg       <= prox_next;
         prox_raw_reg   <= prox_raw_next;
         pulses_reg     <= pulses_next;
         high_latch_reg <= high_latch_next;
      end
   end

   assign prox_pulse_count = pulses_reg;

   always_comb begin
      if (prox_raw_reg) begin
         prox_below_low  = prox_reg[9:2] < prox_low_thresh[7:0];  // R14
         prox_above_high = prox_reg[9:2] > prox_high_thresh[7:0]; // R14
      end else begin
         prox_below_low  = prox_reg < prox_low_thresh;
         prox_above_high = prox_reg > prox_high_thresh;
      end
   end

   // temperature sequencing
   sfr_temp_state_t st_reg, st_next;
   logic [9:0]      temp_reg, temp_next;
   logic            temp_start_reg, temp_start_next;
   logic            temp_armed;

   assign temp_armed = cfg.prox_enable && cfg.timing_enable &&
                       cfg.temp_sensor_on;

   always_comb begin
      st_next         = st_reg;
      temp_next       = temp_reg;
      temp_start_next = 1'b0;
      case (st_reg)
         SFR_IDLE: begin
            if (prox_done && temp_armed) begin
               temp_start_next = 1'b1;                        // R16
               st_next         = SFR_TEMP_WAIT;
            end
         end
         SFR_TEMP_WAIT: begin
            if (!temp_armed) begin
               st_next = SFR_IDLE;
            end else if (temp_done) begin
               temp_next = temp_adc;                          // R16
               st_next   = SFR_IDLE;
            end
         end
         default: begin
            st_next = SFR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg         <= SFR_IDLE;
         temp_reg       <= RST_TEMP;
         temp_start_reg <= 1'b0;
      end else begin
         st_reg         <= st_next;
         temp_reg       <= temp_next;
         temp_start_reg <= temp_start_next;
      end
   end

   assign temp_start = temp_start_reg;

   // register read port, one cycle latency
   logic [7:0] rdata_reg, rdata_next;
   logic       rvalid_reg;
   logic       lvl_lsb;

   assign lvl_lsb = cfg.double_data_mode && buf_level[0];

   always_comb begin
      case (reg_req.addr)
         ADDR_BUF_CTRL: begin
            rdata_next = {rsvd_reg, lvl_lsb, thr_sel_reg, 1'b0,
                          buf_empty, ovf_reg};                // R5 R6
         end
         ADDR_PROX_LOW: begin
            rdata_next = prox_low_byte;
         end
         ADDR_PROX_HIGH: begin
            rdata_next = high_latch_reg;                      // R10
         end
         ADDR_TEMP_LOW: begin
            rdata_next = temp_reg[7:0];                       // R15
         end
         ADDR_TEMP_HIGH: begin
            rdata_next = {6'h00, temp_reg[9:8]};              // R15
         end
         default: begin
            rdata_next = RST_BYTE;
         end
      endcase
      if (!reg_req.rd) begin
         rdata_next = rdata_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg  <= RST_BYTE;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= reg_req.rd;
      end
   end

   assign reg_rdata  = rdata_reg;
   assign reg_rvalid = rvalid_reg;
endmodule : sfr_result_regs

// [sfr_pkg.sv]
// shared constants and types of the buffer and result register bank
package sfr_pkg;
   localparam logic [7:0] ADDR_BUF_CTRL  = 8'hF1;
   localparam logic [7:0] ADDR_PROX_LOW  = 8'hF4;
   localparam logic [7:0] ADDR_PROX_HIGH = 8'hF5;
   localparam logic [7:0] ADDR_TEMP_LOW  = 8'hF6;
   localparam logic [7:0] ADDR_TEMP_HIGH = 8'hF7;

   localparam int BIT_RSVD     = 7;
   localparam int BIT_LVL_LSB  = 6;
   localparam int THR_MSB      = 5;
   localparam int THR_LSB      = 3;
   localparam int BIT_CLEAR    = 2;
   localparam int BIT_EMPTY    = 1;
   localparam int BIT_OVERFLOW = 0;

   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [2:0] RST_THR_SEL  = 3'h0;
   localparam logic       RST_EMPTY    = 1'b1;
   localparam logic [9:0] RST_TEMP     = 10'h000;
   localparam logic [15:0] RST_PROX    = 16'h0000;

   localparam logic [8:0] THR_STEP     = 9'h010;
   localparam logic [15:0] SCALE_NARROW = 16'h0010;
   localparam logic [15:0] SCALE_WIDE   = 16'h0040;
   localparam logic [9:0] PULSE_HIGH_MARK = 10'h300;
   localparam logic [9:0] PULSE_LOW_MARK  = 10'h100;
   localparam logic [6:0] RST_PULSES    = 7'h40;
   localparam logic [6:0] MIN_PULSES    = 7'h01;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_reg_req_t;

   typedef struct packed {
      logic pulse_ctrl_off;
      logic wide_output_on;
      logic prox_enable;
      logic timing_enable;
      logic temp_sensor_on;
      logic double_data_mode;
   } sfr_cfg_t;

   typedef enum logic [1:0] {
      SFR_IDLE      = 2'b00,
      SFR_TEMP_WAIT = 2'b01
   } sfr_temp_state_t;
endpackage : sfr_pkg

// [sfr_fifo.sv]
// measurement buffer with clear, honest full and empty
`timescale 1ns/10ps
module sfr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 512,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             clear,
   input  wire logic             wr_valid,
   input  wire logic [WIDTH-1:0] wr_data,
   output logic                  wr_ready,
   input  wire logic             rd_en,
   output logic      [WIDTH-1:0] rd_data,
   output logic                  empty,
   output logic                  full,
   output logic      [AW:0]      level
);
   import sfr_pkg::*;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
   logic [AW:0]      lvl_reg, lvl_next;
   logic [WIDTH-1:0] rd_data_reg, rd_data_next;
   logic             do_wr, do_rd;

   assign full     = (lvl_reg == (AW+1)'(DEPTH));
   assign empty    = (lvl_reg == '0);
   assign wr_ready = !full;
   assign level    = lvl_reg;
   assign rd_data  = rd_data_reg;

   always_comb begin
      do_wr        = wr_valid && !full && !clear;
      do_rd        = rd_en && !empty && !clear;
      wp_next      = wp_reg;
      rp_next      = rp_reg;
      lvl_next     = lvl_reg;
      rd_data_next = '0;
      if (clear) begin
         wp_next  = '0;
         rp_next  = '0;
         lvl_next = '0;
      end else begin
         if (do_wr) begin
            wp_next = (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
         end
         if (do_rd) begin
            rp_next      = (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
            rd_data_next = mem[rp_reg];
         end
         lvl_next = lvl_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end

   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wp_reg] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_reg      <= '0;
         rp_reg      <= '0;
         lvl_reg     <= '0;
         rd_data_reg <= '0;
      end else begin
         wp_reg      <= wp_next;
         rp_reg      <= rp_next;
         lvl_reg     <= lvl_next;
         rd_data_reg <= rd_data_next;
      end
   end
endmodule : sfr_fifo

// [sfr_result_regs_properties.sv]
// port assertions for the buffer and result register bank
`timescale 1ns/10ps
module sfr_result_regs_chk #(
   parameter int         FIFO_WIDTH = 16,
   parameter logic [6:0] MAX_PULSES = 7'h40
) (
   input wire logic                  clk,
   input wire logic                  arst_n,
   input wire sfr_pkg::sfr_reg_req_t reg_req,
   input wire logic                  reg_rvalid,
   input wire sfr_pkg::sfr_cfg_t     cfg,
   input wire logic                  meas_valid,
   input wire logic                  meas_ready,
   input wire logic                  buf_rd,
   input wire logic [FIFO_WIDTH-1:0] buf_rd_data,
   input wire logic                  buffer_thresh_irq_en,
   input wire logic                  buffer_thresh_flag,
   input wire logic                  buffer_irq,
   input wire logic                  prox_done,
   input wire logic [9:0]            prox_adc,
   input wire logic [6:0]            prox_pulse_count,
   input wire logic                  temp_start
);
   import sfr_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   AST_RD_ANSWER: assert property (reg_rvalid |-> $past(reg_req.rd))
      else $error("read answer without a read");
   AST_CLEAR_READY: assert property (reg_req.wr && reg_req.wdata[BIT_CLEAR]
      && reg_req.addr == ADDR_BUF_CTRL |=> meas_ready)
      else $error("buffer not free after clear");
   AST_EMPTY_ZERO: assert property (buf_rd_data != '0 |-> $past(buf_rd))
      else $error("pop data without a pop");
   AST_FULL_DROP: assert property ($fell(meas_ready) |-> $past(meas_valid))
      else $error("buffer became full without a push");
   AST_IRQ: assert property (buffer_irq == (buffer_thresh_flag
      && buffer_thresh_irq_en))
      else $error("interrupt does not follow flag and enable");
   AST_TEMP_START: assert property (temp_start |-> $past(prox_done
      && cfg.prox_enable && cfg.timing_enable && cfg.temp_sensor_on))
      else $error("temperature start without armed proximity end");
   AST_PULSE_OFF: assert property (cfg.pulse_ctrl_off
      |=> prox_pulse_count == MAX_PULSES)
      else $error("pulse count not at maximum with control off");
   AST_PULSE_HALVE: assert property (prox_done && !cfg.pulse_ctrl_off
      && prox_adc >= 10'h300 && prox_pulse_count > 7'h01
      |=> prox_pulse_count == ($past(prox_pulse_count) >> 1))
      else $error("pulse count not halved on strong signal");
   AST_PULSE_HOLD: assert property (!prox_done && !cfg.pulse_ctrl_off
      |=> $stable(prox_pulse_count))
      else $error("pulse count moved without a measurement");
endmodule : sfr_result_regs_chk

bind sfr_result_regs sfr_result_regs_chk #(
   .FIFO_WIDTH(FIFO_WIDTH),
   .MAX_PULSES(MAX_PULSES)
) chk_u (.clk(clk), .arst_n(arst_n), .reg_req(reg_req),
   .reg_rvalid(reg_rvalid), .cfg(cfg), .meas_valid(meas_valid),
   .meas_ready(meas_ready), .buf_rd(buf_rd), .buf_rd_data(buf_rd_data),
   .buffer_thresh_irq_en(buffer_thresh_irq_en),
   .buffer_thresh_flag(buffer_thresh_flag), .buffer_irq(buffer_irq),
   .prox_done(prox_done), .prox_adc(prox_adc),
   .prox_pulse_count(prox_pulse_count), .temp_start(temp_start));

// [sfr_host_model.sv]
// host model driving register reads, writes and buffer pops
`timescale 1ns/10ps
module sfr_host_model (
   input  wire logic             clk,
   output sfr_pkg::sfr_reg_req_t reg_req,
   input  wire logic [7:0]       reg_rdata,
   input  wire logic             reg_rvalid,
   output logic                  buf_rd,
   input  wire logic [15:0]      buf_rd_data,
   output logic                  ambient_light_unit_on
);
   import sfr_pkg::*;
   initial begin
      reg_req = '0;
      buf_rd  = 1'b0;
   end
   // ambient unit kept off so clears are always legal
   assign ambient_light_unit_on = 1'b0;

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_req.rd   <= 1'b1;
      reg_req.addr <= a;
      @(posedge clk);
      reg_req.rd <= 1'b0;
      #1;
      d = reg_rvalid ? reg_rdata : 8'hEE;
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_req.wr    <= 1'b1;
      reg_req.addr  <= a;
      reg_req.wdata <= v;
      @(posedge clk);
      reg_req.wr <= 1'b0;
   endtask : wr

   // low byte first so the high byte comes from the latch
   task automatic rd_pair(output logic [15:0] v);
      logic [7:0] lo;
      logic [7:0] hi;
      rd(ADDR_PROX_LOW, lo);
      rd(ADDR_PROX_HIGH, hi);
      v = {hi, lo};
   endtask : rd_pair

   // a pop doubles as the dummy read that drops overflow
   task automatic pop(output logic [15:0] d);
      @(posedge clk);
      buf_rd <= 1'b1;
      @(posedge clk);
      buf_rd <= 1'b0;
      #1;
      d = buf_rd_data;
   endtask : pop
endmodule : sfr_host_model

// [sfr_result_regs_tb_top.sv]
// self-checking bench for the buffer and result register bank
`timescale 1ns/10ps
module sfr_result_regs_tb_top;
   import sfr_pkg::*;
   logic         clk;
   logic         arst_n;
   sfr_reg_req_t reg_req;
   logic [7:0]   reg_rdata;
   logic         reg_rvalid;
   sfr_cfg_t     cfg;
   logic         alu_on;
   logic         meas_valid;
   logic [15:0]  meas_data;
   logic         meas_ready;
   logic         buf_rd;
   logic [15:0]  buf_rd_data;
   logic         irq_en;
   logic         flag_clr;
   logic         flag;
   logic         irq;
   logic         prox_done;
   logic [9:0]   prox_adc;
   logic [6:0]   pulses;
   logic [15:0]  lo_th;
   logic [15:0]  hi_th;
   logic         below;
   logic         above;
   logic         temp_start;
   logic         temp_done;
   logic [9:0]   temp_adc;
   int           err_total;
   int           comparisons;

   sfr_result_regs #(.FIFO_DEPTH(32)) dut_u (.clk(clk), .arst_n(arst_n),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .cfg(cfg), .ambient_light_unit_on(alu_on), .meas_valid(meas_valid),
      .meas_data(meas_data), .meas_ready(meas_ready), .buf_rd(buf_rd),
      .buf_rd_data(buf_rd_data), .buffer_thresh_irq_en(irq_en),
      .thresh_flag_clr(flag_clr), .buffer_thresh_flag(flag),
      .buffer_irq(irq), .prox_done(prox_done), .prox_adc(prox_adc),
      .prox_pulse_count(pulses), .prox_low_thresh(lo_th),
      .prox_high_thresh(hi_th), .prox_below_low(below),
      .prox_above_high(above), .temp_start(temp_start),
      .temp_done(temp_done), .temp_adc(temp_adc));

   sfr_host_model host_u (.clk(clk), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .buf_rd(buf_rd),
      .buf_rd_data(buf_rd_data), .ambient_light_unit_on(alu_on));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task automatic chkb(input logic s, input logic e);
      chk({15'h0000, s}, {15'h0000, e});
   endtask : chkb

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host_u.rd(a, d);
      chk({8'h00, d}, {8'h00, e});
   endtask : rd_chk

   task automatic pop_chk(input logic [15:0] e);
      logic [15:0] d;
      host_u.pop(d);
      chk(d, e);
   endtask : pop_chk

   task automatic pair_chk(input logic [15:0] e);
      logic [15:0] d;
      host_u.rd_pair(d);
      chk(d, e);
   endtask : pair_chk

   task automatic push(input logic [15:0] d);
      @(posedge clk);
      meas_valid <= 1'b1;
      meas_data  <= d;
      @(posedge clk);
      meas_valid <= 1'b0;
   endtask : push

   task automatic pdone(input logic [9:0] a);
      @(posedge clk);
      prox_done <= 1'b1;
      prox_adc  <= a;
      @(posedge clk);
      prox_done <= 1'b0;
      #1;
   endtask : pdone

   task automatic t_reset;
      rd_chk(ADDR_PROX_LOW, 8'h00);
      rd_chk(ADDR_PROX_HIGH, 8'h00);
      rd_chk(ADDR_TEMP_LOW, 8'h00);
      rd_chk(ADDR_TEMP_HIGH, 8'h00);
      rd_chk(ADDR_BUF_CTRL, 8'h02);
      rd_chk(8'h10, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_basic;
      push(16'hA5C3);
      rd_chk(ADDR_BUF_CTRL, 8'h00);
      pop_chk(16'hA5C3);
      pop_chk(16'h0000);
      rd_chk(ADDR_BUF_CTRL, 8'h02);
      $display("test basic done");
   endtask : t_basic

   task automatic t_thresh;
      host_u.wr(ADDR_BUF_CTRL, 8'h08);
      repeat (15) push(16'h1234);
      repeat (2) @(posedge clk);
      #1;
      chkb(flag, 1'b0);
      push(16'h1234);
      repeat (2) @(posedge clk);
      #1;
      chkb(flag, 1'b1);
      chkb(irq, 1'b0);
      @(posedge clk);
      irq_en <= 1'b1;
      #1;
      chkb(irq, 1'b1);
      rd_chk(ADDR_BUF_CTRL, 8'h08);
      $display("test threshold done");
   endtask : t_thresh

   task automatic t_full;
      repeat (16) push(16'h5678);
      #1;
      chkb(meas_ready, 1'b0);
      push(16'h9ABC);
      rd_chk(ADDR_BUF_CTRL, 8'h09);
      host_u.wr(ADDR_BUF_CTRL, 8'h0C);
      rd_chk(ADDR_BUF_CTRL, 8'h0B);
      pop_chk(16'h0000);
      rd_chk(ADDR_BUF_CTRL, 8'h0A);
      $display("test full done");
   endtask : t_full

   // double mode doubles the threshold; a clear loses to a standing set
   task automatic t_double;
      @(posedge clk);
      flag_clr             <= 1'b1;
      cfg.double_data_mode <= 1'b1;
      @(posedge clk);
      flag_clr <= 1'b0;
      #1;
      chkb(flag, 1'b0);
      repeat (17) push(16'h0F0F);
      repeat (2) @(posedge clk);
      #1;
      chkb(flag, 1'b0);
      rd_chk(ADDR_BUF_CTRL, 8'h48);
      repeat (15) push(16'h0F0F);
      @(posedge clk);
      flag_clr <= 1'b1;
      @(posedge clk);
      flag_clr <= 1'b0;
      #1;
      chkb(flag, 1'b1);
      $display("test double mode done");
   endtask : t_double

   task automatic t_prox;
      pdone(10'h2A7);
      rd_chk(ADDR_PROX_LOW, 8'hA9);
      rd_chk(ADDR_PROX_HIGH, 8'h03);
      chkb(below, 1'b1);
      chkb(above, 1'b1);
      @(posedge clk);
      cfg.pulse_ctrl_off <= 1'b0;
      cfg.wide_output_on <= 1'b1;
      pdone(10'h3FF);
      pair_chk(16'h03FF);
      chk({9'h000, pulses}, 16'h0020);
      pdone(10'h3FF);
      rd_chk(ADDR_PROX_LOW, 8'hFE);
      @(posedge clk);
      cfg.wide_output_on <= 1'b0;
      pdone(10'h3FF);
      rd_chk(ADDR_PROX_HIGH, 8'h07);
      pair_chk(16'h03FF);
      pdone(10'h040);
      pair_chk(16'h0080);
      chk({9'h000, pulses}, 16'h0010);
      $display("test proximity done");
   endtask : t_prox

   task automatic t_temp;
      @(posedge clk);
      cfg.prox_enable    <= 1'b1;
      cfg.timing_enable  <= 1'b1;
      cfg.temp_sensor_on <= 1'b1;
      pdone(10'h100);
      chkb(temp_start, 1'b1);
      @(posedge clk);
      temp_done <= 1'b1;
      temp_adc  <= 10'h2C5;
      @(posedge clk);
      temp_done <= 1'b0;
      rd_chk(ADDR_TEMP_LOW, 8'hC5);
      rd_chk(ADDR_TEMP_HIGH, 8'h02);
      $display("test temperature done");
   endtask : t_temp

   task automatic give_verdict;
      $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   // the whole run needs well under a thousand cycles
   initial begin
      #(50 * 5000);
      err_total++;
      give_verdict();
   end

   initial begin
      err_total   = 0;
      comparisons = 0;
      arst_n      = 1'b0;
      cfg         = '0;
      cfg.pulse_ctrl_off = 1'b1;
      meas_valid  = 1'b0;
      meas_data   = 16'h0000;
      irq_en      = 1'b0;
      flag_clr    = 1'b0;
      prox_done   = 1'b0;
      prox_adc    = 10'h000;
      lo_th       = 16'h01AA;
      hi_th       = 16'h01A8;
      temp_done   = 1'b0;
      temp_adc    = 10'h000;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_basic();
      t_thresh();
      t_full();
      t_double();
      t_prox();
      t_temp();
      give_verdict();
   end
endmodule : sfr_result_regs_tb_top
